// file: src/cache_cfg_pkg.sv
// shared constants and types for the cache configuration block
package cache_cfg_pkg;
  typedef logic [31:0] word_t;
  typedef logic [1:0]  field2_t;
  typedef logic [8:0]  region_len_t;
  typedef logic [9:0]  block_cnt_t;
  typedef logic [9:0]  flush_cnt_t;
  typedef logic [12:0] ctrl_two_t;

  // register byte addresses
  localparam word_t ADDR_CONTROL_ONE = 32'h400C_3000;
  localparam word_t ADDR_LINE_SIZE   = 32'h400C_3004;
  localparam word_t ADDR_WAY_COUNT   = 32'h400C_3008;
  localparam word_t ADDR_CONTROL_TWO = 32'h400C_3020;
  localparam word_t ADDR_HIT_COUNTER = 32'h400C_3028;
  localparam word_t ADDR_MISS_COUNTER = 32'h400C_302C;

  // field positions
  localparam int FLUSH_BIT       = 0;
  localparam int KEEP_ZERO_BIT   = 1;
  localparam int FLASH_REMAP_BIT = 12;
  localparam int OTP_REMAP_BIT   = 11;
  localparam int CLK_GATE_BIT    = 10;
  localparam int ARRAY_WRITE_BIT = 9;
  localparam int REGION_LEN_MSB  = 8;
  localparam int CTRL_TWO_MSB    = 12;
  localparam int HIT_WIDTH       = 19;
  localparam int MISS_WIDTH      = 18;
  localparam int HTRANS_ACTIVE_BIT = 1;

  // reset values
  localparam field2_t   LINE_SIZE_RESET = 2'h0;
  localparam field2_t   WAY_COUNT_RESET = 2'h2;
  localparam ctrl_two_t CTRL_TWO_RESET  = 13'h0000;

  // field encodings and their decoded forms
  localparam field2_t    LINE_SEL_8  = 2'h0;
  localparam field2_t    LINE_SEL_16 = 2'h1;
  localparam field2_t    LINE_SEL_32 = 2'h2;
  localparam field2_t    WAYS_SEL_1  = 2'h0;
  localparam field2_t    WAYS_SEL_2  = 2'h1;
  localparam field2_t    WAYS_SEL_4  = 2'h2;
  localparam logic [5:0] LINE_BYTES_8  = 6'h08;
  localparam logic [5:0] LINE_BYTES_16 = 6'h10;
  localparam logic [5:0] LINE_BYTES_32 = 6'h20;
  localparam logic [2:0] WAYS_ONE  = 3'h1;
  localparam logic [2:0] WAYS_TWO  = 3'h2;
  localparam logic [2:0] WAYS_FOUR = 3'h4;

  // flush timing in bus clock cycles, chosen by data ram size
  localparam flush_cnt_t FLUSH_CYCLES_8K  = 10'h100;
  localparam flush_cnt_t FLUSH_CYCLES_16K = 10'h200;
  localparam bit         DATA_RAM_16K     = 1'b1;
  localparam flush_cnt_t FLUSH_CYCLES = DATA_RAM_16K ? FLUSH_CYCLES_16K : FLUSH_CYCLES_8K;
  localparam flush_cnt_t FLUSH_LAST   = FLUSH_CYCLES - 10'h001;

  // region size in 64 kbyte blocks; 16 Mbyte cap when otp is cached too
  localparam block_cnt_t ONE_BLOCK             = 10'h001;
  localparam block_cnt_t OTP_CACHED_MAX_BLOCKS = 10'h100;

  typedef enum logic [1:0] {FLUSH_IDLE = 2'b00, FLUSH_RUN = 2'b01} flush_state_e;
  typedef enum logic {BUS_IDLE = 1'b0, BUS_READ = 1'b1} bus_state_e;
endpackage

// file: src/cache_controller_config_and_counters.sv
// cache controller configuration registers, flush and hit/miss tallies
//
// Our own choice: register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
module cache_controller_config_and_counters (
  input  wire logic                     clock_in,
  input  wire logic                     rst_in,
  // ahb-lite slave
  input  wire logic                     hsel_in,
  input  wire cache_cfg_pkg::word_t     haddr_in,
  input  wire logic [1:0]               htrans_in,
  input  wire logic                     hwrite_in,
  input  wire logic [2:0]               hsize_in,
  input  wire cache_cfg_pkg::word_t     hwdata_in,
  input  wire logic                     hready_in,
  output logic                          hreadyout_out,
  output logic                          hresp_out,
  output cache_cfg_pkg::word_t          hrdata_out,
  // lookup results from the controller core
  input  wire logic                     lookup_valid_in,
  input  wire logic                     lookup_hit_in,
  input  wire logic                     monitor_run_in,
  // configuration towards the controller core
  output logic                          flush_busy_out,
  output cache_cfg_pkg::flush_cnt_t     tag_clear_index_out,
  output logic [5:0]                    line_len_bytes_out,
  output logic [2:0]                    ways_out,
  output logic                          flash_cacheable_when_remapped_out,
  output logic                          otp_cacheable_when_remapped_out,
  output logic                          controller_clock_gate_en_out,
  output logic                          array_write_en_out,
  output logic                          cache_enable_out,
  output cache_cfg_pkg::block_cnt_t     cacheable_blocks_out
);
  import cache_cfg_pkg::*;

  bus_state_e       bus_state_q, bus_state_d;
  word_t            addr_q,      addr_d;
  logic             wr_pend_q,   wr_pend_d;
  logic             hreadyout_q, hreadyout_d;
  word_t            hrdata_q,    hrdata_d;
  logic             addr_take;
  logic             wr_ctrl1, wr_line, wr_way, wr_ctrl2, wr_hit, wr_miss;
  word_t            read_word;
  logic             keep_zero_q, keep_zero_d;
  field2_t          line_size_q, line_size_d;
  field2_t          way_count_q, way_count_d;
  ctrl_two_t        ctrl2_q,     ctrl2_d;
  logic             flush_start;
  logic [HIT_WIDTH-1:0]  hit_count;
  logic [MISS_WIDTH-1:0] miss_count;
  logic             hit_step, miss_step;
  logic [5:0]       line_bytes_q, line_bytes_d;
  logic [2:0]       ways_q,       ways_d;
  logic             enable_q,     enable_d;
  block_cnt_t       blocks_q,     blocks_d;
  block_cnt_t       blocks_raw;
  region_len_t      region_len;

  // a transfer is taken when selected, ready and nonseq or seq
  assign addr_take = hsel_in & hready_in & htrans_in[HTRANS_ACTIVE_BIT];

  // writes finish without wait; reads insert one wait state so that a
  // read right behind a write sees the freshly written value
  always_comb begin
    bus_state_d = bus_state_q;
    addr_d      = addr_q;
    wr_pend_d   = 1'b0;
    hreadyout_d = 1'b1;
    hrdata_d    = hrdata_q;
    case (bus_state_q)
      BUS_IDLE: if (addr_take) begin
        addr_d    = haddr_in;
        wr_pend_d = hwrite_in;
        if (!hwrite_in) begin
          bus_state_d = BUS_READ;
          hreadyout_d = 1'b0;
        end
      end
      BUS_READ: begin
        hrdata_d    = read_word;
        bus_state_d = BUS_IDLE;
      end
      default: bus_state_d = BUS_IDLE;
    endcase
  end

  // bus slave registers
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      bus_state_q <= BUS_IDLE;
      addr_q      <= '0;
      wr_pend_q   <= 1'b0;
      hreadyout_q <= 1'b1;
      hrdata_q    <= '0;
    end else begin
      bus_state_q <= bus_state_d;
      addr_q      <= addr_d;
      wr_pend_q   <= wr_pend_d;
      hreadyout_q <= hreadyout_d;
      hrdata_q    <= hrdata_d;
    end
  end

  // write strobes in the data phase; unmapped writes are dropped
  always_comb begin
    wr_ctrl1 = 1'b0;
    wr_line  = 1'b0;
    wr_way   = 1'b0;
    wr_ctrl2 = 1'b0;
    wr_hit   = 1'b0;
    wr_miss  = 1'b0;
    if (wr_pend_q) begin
      if (addr_q == ADDR_CONTROL_ONE) begin
        wr_ctrl1 = 1'b1;
      end else if (addr_q == ADDR_LINE_SIZE) begin
        wr_line = 1'b1;
      end else if (addr_q == ADDR_WAY_COUNT) begin
        wr_way = 1'b1;
      end else if (addr_q == ADDR_CONTROL_TWO) begin
        wr_ctrl2 = 1'b1;
      end else if (addr_q == ADDR_HIT_COUNTER) begin
        wr_hit = 1'b1;
      end else if (addr_q == ADDR_MISS_COUNTER) begin
        wr_miss = 1'b1;
      end
    end
  end

  // read mux; reserved bits other than the stored reserved control bit read zero, as do unmapped addresses
  always_comb begin
    read_word = '0;
    if (addr_q == ADDR_CONTROL_ONE) begin
      read_word[KEEP_ZERO_BIT] = keep_zero_q; // flush bit stays 0
    end else if (addr_q == ADDR_LINE_SIZE) begin
      read_word[1:0] = line_size_q;
    end else if (addr_q == ADDR_WAY_COUNT) begin
      read_word[1:0] = way_count_q;
    end else if (addr_q == ADDR_CONTROL_TWO) begin
      read_word[CTRL_TWO_MSB:0] = ctrl2_q;
    end else if (addr_q == ADDR_HIT_COUNTER) begin
      read_word[HIT_WIDTH-1:0] = hit_count;
    end else if (addr_q == ADDR_MISS_COUNTER) begin
      read_word[MISS_WIDTH-1:0] = miss_count;
    end
  end

  // configuration register next values; the reserved control bit is
  // stored as written, since nothing in the core looks at it
  always_comb begin
    keep_zero_d = keep_zero_q;
    line_size_d = line_size_q;
    way_count_d = way_count_q;
    ctrl2_d     = ctrl2_q;
    if (wr_ctrl1) begin
      keep_zero_d = hwdata_in[KEEP_ZERO_BIT];
    end
    if (wr_line) begin
      line_size_d = hwdata_in[1:0];
    end
    if (wr_way) begin
      way_count_d = hwdata_in[1:0];
    end
    if (wr_ctrl2) begin
      ctrl2_d = hwdata_in[CTRL_TWO_MSB:0];
    end
  end

  // configuration registers
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      keep_zero_q <= 1'b0;
      line_size_q <= LINE_SIZE_RESET;
      way_count_q <= WAY_COUNT_RESET;
      ctrl2_q     <= CTRL_TWO_RESET;
    end else begin
      keep_zero_q <= keep_zero_d;
      line_size_q <= line_size_d;
      way_count_q <= way_count_d;
      ctrl2_q     <= ctrl2_d;
    end
  end

  // a one in the flush bit starts a full tag walk
  assign flush_start = wr_ctrl1 & hwdata_in[FLUSH_BIT];

  flush_sequencer u_flush (
    .clock_in  (clock_in),
    .rst_in    (rst_in),
    .start_in  (flush_start),
    .busy_out  (flush_busy_out),
    .index_out (tag_clear_index_out)
  );

  // each lookup steps exactly one tally, only while the monitor runs
  assign hit_step  = monitor_run_in & lookup_valid_in & lookup_hit_in;
  assign miss_step = monitor_run_in & lookup_valid_in & ~lookup_hit_in;

  event_tally #(.WIDTH(HIT_WIDTH)) u_hits (
    .clock_in      (clock_in),
    .rst_in        (rst_in),
    .load_in       (wr_hit),
    .load_value_in (hwdata_in[HIT_WIDTH-1:0]),
    .step_in       (hit_step),
    .count_out     (hit_count)
  );

  event_tally #(.WIDTH(MISS_WIDTH)) u_misses (
    .clock_in      (clock_in),
    .rst_in        (rst_in),
    .load_in       (wr_miss),
    .load_value_in (hwdata_in[MISS_WIDTH-1:0]),
    .step_in       (miss_step),
    .count_out     (miss_count)
  );

  assign region_len = ctrl2_q[REGION_LEN_MSB:0];
  assign blocks_raw = {1'b0, region_len} + ONE_BLOCK;

  // decoded configuration; reserved codes give zero so the core can
  // tell them apart instead of guessing a geometry
  always_comb begin
    case (line_size_q)
      LINE_SEL_8:  line_bytes_d = LINE_BYTES_8;
      LINE_SEL_16: line_bytes_d = LINE_BYTES_16;
      LINE_SEL_32: line_bytes_d = LINE_BYTES_32;
      default:     line_bytes_d = '0;
    endcase
    case (way_count_q)
      WAYS_SEL_1: ways_d = WAYS_ONE;
      WAYS_SEL_2: ways_d = WAYS_TWO;
      WAYS_SEL_4: ways_d = WAYS_FOUR;
      default:    ways_d = '0;
    endcase
    enable_d = (region_len != '0);
    if (region_len == '0) begin
      blocks_d = '0;
    end else if (ctrl2_q[OTP_REMAP_BIT] && (blocks_raw > OTP_CACHED_MAX_BLOCKS)) begin
      blocks_d = OTP_CACHED_MAX_BLOCKS;
    end else begin
      blocks_d = blocks_raw;
    end
  end

  // decoded output registers
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      line_bytes_q <= LINE_BYTES_8; // agrees with the line size field reset
      ways_q       <= WAYS_FOUR;    // agrees with the way count field reset
      enable_q     <= 1'b0;
      blocks_q     <= '0;
    end else begin
      line_bytes_q <= line_bytes_d;
      ways_q       <= ways_d;
      enable_q     <= enable_d;
      blocks_q     <= blocks_d;
    end
  end

  // outputs; array writes carry no extra guard here
  assign hreadyout_out      = hreadyout_q;
  assign hresp_out          = 1'b0;
  assign hrdata_out         = hrdata_q;
  assign line_len_bytes_out = line_bytes_q;
  assign ways_out           = ways_q;
  assign cache_enable_out   = enable_q;
  assign cacheable_blocks_out = blocks_q;
  assign flash_cacheable_when_remapped_out = ctrl2_q[FLASH_REMAP_BIT];
  assign otp_cacheable_when_remapped_out   = ctrl2_q[OTP_REMAP_BIT];
  assign controller_clock_gate_en_out      = ctrl2_q[CLK_GATE_BIT];
  assign array_write_en_out                = ctrl2_q[ARRAY_WRITE_BIT];

  // helper: busy cycles since the last flush start, held once the walk ends
  flush_cnt_t flush_age_q;
  always_ff @(posedge clock_in) begin
    if (rst_in || flush_start) begin
      flush_age_q <= '0;
    end else if (flush_busy_out) begin
      flush_age_q <= flush_age_q + 10'h001;
    end
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  flush_read_a: assert property (
    bus_state_q == BUS_READ && addr_q == ADDR_CONTROL_ONE |=> !hrdata_out[FLUSH_BIT])
    else $error("flush bit read back as one");

  flush_start_a: assert property (
    flush_start |=> flush_busy_out && tag_clear_index_out == '0)
    else $error("flush did not start at entry zero");

  flush_length_a: assert property (
    $fell(flush_busy_out) |-> flush_age_q == FLUSH_CYCLES)
    else $error("flush length wrong");

  line_decode_a: assert property (
    line_size_q == LINE_SEL_32 ##1 line_size_q == LINE_SEL_32
      |-> line_len_bytes_out == LINE_BYTES_32)
    else $error("line size decode wrong");

  way_decode_a: assert property (
    way_count_q == WAYS_SEL_1 |=> ways_out == WAYS_ONE || $changed(way_count_q))
    else $error("way count decode wrong");

  flash_remap_a: assert property (
    wr_ctrl2 |=> flash_cacheable_when_remapped_out == $past(hwdata_in[FLASH_REMAP_BIT]))
    else $error("flash remap bit not taken");

  otp_remap_a: assert property (
    wr_ctrl2 |=> otp_cacheable_when_remapped_out == $past(hwdata_in[OTP_REMAP_BIT]))
    else $error("otp remap bit not taken");

  gate_write_a: assert property (
    wr_ctrl2 |=> controller_clock_gate_en_out == $past(hwdata_in[CLK_GATE_BIT]))
    else $error("clock gate bit not taken");

  array_write_a: assert property (
    wr_ctrl2 |=> array_write_en_out == $past(hwdata_in[ARRAY_WRITE_BIT]))
    else $error("array write bit not taken");

  region_off_a: assert property (
    wr_ctrl2 && hwdata_in[REGION_LEN_MSB:0] == '0 |-> ##2 !cache_enable_out
      && cacheable_blocks_out == '0)
    else $error("zero length did not disable caching");

  otp_cap_a: assert property (
    otp_cacheable_when_remapped_out |=> cacheable_blocks_out <= OTP_CACHED_MAX_BLOCKS)
    else $error("flash length above cap with otp cached");

  hit_step_a: assert property (
    hit_step && !wr_hit |=> hit_count == $past(hit_count) + 19'h00001
      && $stable(miss_count) || $past(wr_miss))
    else $error("hit did not step the hit tally alone");

  tally_freeze_a: assert property (
    !monitor_run_in && !wr_hit && !wr_miss |=> $stable(hit_count) && $stable(miss_count))
    else $error("tally moved while monitor stopped");

  read_wait_a: assert property (
    addr_take && !hwrite_in |=> !hreadyout_out ##1 hreadyout_out)
    else $error("read answer timing wrong");

  flush_done_c: cover property ($fell(flush_busy_out));
  miss_step_c:  cover property (miss_step ##1 hit_step);
  read_c:       cover property (bus_state_q == BUS_READ && addr_q == ADDR_HIT_COUNTER);
  cap_c:        cover property (cacheable_blocks_out == OTP_CACHED_MAX_BLOCKS);
endmodule // cache_controller_config_and_counters
`default_nettype wire

// file: src/event_tally.sv
// loadable event counter that wraps at its width
`timescale 1ns/100ps
`default_nettype none
module event_tally #(
  parameter int WIDTH = 18
) (
  input  wire logic             clock_in,
  input  wire logic             rst_in,
  input  wire logic             load_in,
  input  wire logic [WIDTH-1:0] load_value_in,
  input  wire logic             step_in,
  output logic      [WIDTH-1:0] count_out
);
  logic [WIDTH-1:0] count_q, count_d;

  // a software write wins over a step in the same cycle
  always_comb begin
    count_d = count_q;
    if (load_in) begin
      count_d = load_value_in;
    end else if (step_in) begin
      count_d = count_q + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  // count register, zero after reset
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

  assign count_out = count_q;
endmodule // event_tally
`default_nettype wire

// file: src/flush_sequencer.sv
// walks every tag entry once to invalidate the whole cache
`timescale 1ns/100ps
`default_nettype none
module flush_sequencer (
  input  wire logic              clock_in,
  input  wire logic              rst_in,
  input  wire logic              start_in,
  output logic                   busy_out,
  output cache_cfg_pkg::flush_cnt_t index_out
);
  import cache_cfg_pkg::*;

  flush_state_e state_q, state_d;
  flush_cnt_t   index_q, index_d;
  logic         busy_q,  busy_d;

  // a new start restarts the walk from entry zero
  always_comb begin
    state_d = state_q;
    index_d = index_q;
    case (state_q)
      FLUSH_IDLE: if (start_in) begin
        state_d = FLUSH_RUN;
        index_d = '0;
      end
      FLUSH_RUN: if (start_in) begin
        index_d = '0;
      end else if (index_q == FLUSH_LAST) begin
        state_d = FLUSH_IDLE;
      end else begin
        index_d = index_q + 10'h001;
      end
      default: state_d = FLUSH_IDLE;
    endcase
    busy_d = (state_d == FLUSH_RUN);
  end

  // state registers
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state_q <= FLUSH_IDLE;
      index_q <= '0;
      busy_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      index_q <= index_d;
      busy_q  <= busy_d;
    end
  end

  assign busy_out  = busy_q;
  assign index_out = index_q;
endmodule // flush_sequencer
`default_nettype wire

// file: test/cache_controller_config_and_counters_bench.sv
// self-checking bench for the cache configuration and tally block
`timescale 1ns/100ps
`default_nettype none
module cache_controller_config_and_counters_bench;
  import cache_cfg_pkg::*;
  logic clock_in, rst_in, hsel, hwrite, hready, hresp, run, en, lv, lh;
  logic busy, fl, otp, cg, awe, cen;
  logic [1:0] htrans;
  logic [2:0] hsize, ways;
  logic [5:0] line_len;
  word_t haddr, hwdata, hrdata, mh, mm, d;
  flush_cnt_t idx;
  block_cnt_t blocks;
  integer seed = 32'hc4fd;
  int err_count = 0;
  int checks = 0;
  int cycles = 0;
  int n;
  word_t addrs [6] = '{ADDR_CONTROL_ONE, ADDR_LINE_SIZE, ADDR_WAY_COUNT,
                       ADDR_CONTROL_TWO, ADDR_HIT_COUNTER, ADDR_MISS_COUNTER};
  word_t rstv [6] = '{32'h0, 32'h0, 32'h2, 32'h0, 32'h0, 32'h0};
  word_t mask [6] = '{32'h2, 32'h3, 32'h3, 32'h1FFF, 32'h7FFFF, 32'h3FFFF};
  logic [8:0] lens [4] = '{9'h000, 9'h001, 9'h005, 9'h1FF};

  cache_controller_config_and_counters DUT (
    .clock_in(clock_in), .rst_in(rst_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
    .hready_in(hready), .hreadyout_out(hready), .hresp_out(hresp), .hrdata_out(hrdata),
    .lookup_valid_in(lv), .lookup_hit_in(lh), .monitor_run_in(run),
    .flush_busy_out(busy), .tag_clear_index_out(idx), .line_len_bytes_out(line_len),
    .ways_out(ways), .flash_cacheable_when_remapped_out(fl),
    .otp_cacheable_when_remapped_out(otp), .controller_clock_gate_en_out(cg),
    .array_write_en_out(awe), .cache_enable_out(cen), .cacheable_blocks_out(blocks)
  );

  fetch_source_model partner (
    .clock_in(clock_in), .rst_in(rst_in), .enable_in(en), .run_in(run),
    .lookup_valid_out(lv), .lookup_hit_out(lh), .hits_out(mh), .misses_out(mm)
  );

  // 20 MHz bus clock
  initial begin
    clock_in = 1'b0;
    forever #25 clock_in = ~clock_in;
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input word_t e, input word_t g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one single-word transfer; waits are cut only by the cycle ceiling
  task automatic bus(input logic w, input word_t a, input word_t wd, output word_t rd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge clock_in);
    while (hready !== 1'b1) @(posedge clock_in);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clock_in);
    while (hready !== 1'b1) @(posedge clock_in);
    rd = hrdata;
  endtask

  task automatic wr(input word_t a, input word_t v);
    word_t x;
    bus(1'b1, a, v, x);
  endtask

  task automatic rdc(input string nm, input word_t a, input word_t e);
    word_t x;
    bus(1'b0, a, 32'h0, x);
    chk(nm, e, x);
    chk("response", 32'h0, 32'(hresp));
  endtask

  function automatic word_t exp_line(input int c);
    return (c == 0) ? 32'h8 : (c == 1) ? 32'h10 : (c == 2) ? 32'h20 : 32'h0;
  endfunction

  function automatic word_t exp_ways(input int c);
    return (c == 0) ? 32'h1 : (c == 1) ? 32'h2 : (c == 2) ? 32'h4 : 32'h0;
  endfunction

  // 64 KB blocks; capped at 16 MB while otp is cached as well
  function automatic word_t exp_blk(input word_t v);
    word_t b;
    b = (v[8:0] == 9'h0) ? 32'h0 : {23'h0, v[8:0]} + 32'h1;
    if (v[11] && b > 32'h100) b = 32'h100;
    return b;
  endfunction

  // hang guard: a run this long means a wait never ended
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      test_done();
    end
  end

  initial begin
    {rst_in, hsel, hwrite, run, en} = 5'b10000;
    htrans = 2'h0;
    hsize = 3'h2; // whole words only
    haddr = 32'h0;
    hwdata = 32'h0;
    repeat (3) @(posedge clock_in);
    rst_in <= 1'b0;
    for (int i = 0; i < 6; i++) rdc("reset value", addrs[i], rstv[i]);
    // random write and read back, back to back
    for (int i = 0; i < 6; i++) begin
      d = $random(seed);
      if (i == 0) d[1] = 1'b0;
      wr(addrs[i], d);
      rdc("read back", addrs[i], d & mask[i]);
    end
    wr(32'h400C_3010, 32'hFFFF_FFFF);
    rdc("unmapped", 32'h400C_3010, 32'h0);
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_LINE_SIZE, c);
      wr(ADDR_WAY_COUNT, c);
      repeat (3) @(posedge clock_in);
      chk("line bytes", exp_line(c), 32'(line_len));
      chk("ways", exp_ways(c), 32'(ways));
    end
    for (int k = 0; k < 8; k++) begin
      d = $random(seed) & 32'h1600;
      d[11] = k[2];
      d[8:0] = lens[k % 4];
      wr(ADDR_CONTROL_TWO, d);
      repeat (3) @(posedge clock_in);
      chk("ctrl2 bits", 32'(d[12:9]), 32'({fl, otp, cg, awe}));
      chk("blocks", exp_blk(d), 32'(blocks));
      chk("enable", 32'(d[8:0] != 9'h0), 32'(cen));
    end
    wr(ADDR_CONTROL_TWO, 32'h0);
    wr(ADDR_LINE_SIZE, 32'h0);
    wr(ADDR_CONTROL_ONE, 32'h1);
    n = 0;
    @(posedge clock_in);
    chk("first index", 32'h0, 32'(idx));
    while (busy === 1'b1) begin
      chk("tag index", 32'(n), 32'(idx));
      n++;
      @(posedge clock_in);
    end
    chk("flush cycles", 32'(FLUSH_CYCLES), n);
    wr(ADDR_WAY_COUNT, 32'h0);
    wr(ADDR_HIT_COUNTER, 32'h0);
    wr(ADDR_MISS_COUNTER, 32'h0);
    en <= 1'b1;
    repeat (400) begin
      run <= 1'($random(seed));
      @(posedge clock_in);
    end
    // lookups go on with run low; the tallies must hold meanwhile
    run <= 1'b0;
    repeat (20) @(posedge clock_in);
    rdc("hit tally", ADDR_HIT_COUNTER, mh & 32'h7FFFF);
    rdc("miss tally", ADDR_MISS_COUNTER, mm & 32'h3FFFF);
    // a reset in mid-run must bring every register back to its reset value
    rst_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    rst_in <= 1'b0;
    for (int i = 0; i < 6; i++) rdc("second reset", addrs[i], rstv[i]);
    chk("reset line bytes", 32'h8, 32'(line_len));
    chk("reset ways", 32'h4, 32'(ways));
    test_done();
  end
endmodule // cache_controller_config_and_counters_bench
`default_nettype wire

// file: test/fetch_source_model.sv
// fetch-side model: random cacheable lookups plus its own record of them
`timescale 1ns/100ps
`default_nettype none
module fetch_source_model (
  input  wire logic   clock_in,
  input  wire logic   rst_in,
  input  wire logic   enable_in,
  input  wire logic   run_in,
  output logic        lookup_valid_out,
  output logic        lookup_hit_out,
  output logic [31:0] hits_out,
  output logic [31:0] misses_out
);
  integer seed = 32'h5A3;
  // bursty lookups, one a cycle at most; the hit line wanders even when idle
  always @(posedge clock_in) begin
    if (rst_in) begin
      lookup_valid_out <= 1'b0;
      lookup_hit_out <= 1'b0;
      hits_out <= 32'h0;
      misses_out <= 32'h0;
    end else begin
      lookup_valid_out <= enable_in && (($random(seed) % 4) != 0);
      lookup_hit_out <= 1'($random(seed));
      // only lookups taken while the monitor runs may be tallied
      if (lookup_valid_out && run_in && lookup_hit_out) hits_out <= hits_out + 1;
      if (lookup_valid_out && run_in && !lookup_hit_out) misses_out <= misses_out + 1;
    end
  end
endmodule // fetch_source_model
`default_nettype wire
